// ---- tb/crf_checker.sv ----
// checker for the cpu register file, bound to the design's ports
// assumes a single clk domain and the active low reset rstn
`timescale 1ns/1ps
module crf_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire crf_pkg::crf_write_type wr,
    input wire crf_pkg::crf_pc_ctl_type pc_ctl,
    input wire crf_pkg::crf_addr_req_type addr_req,
    input wire logic [15:0] acc_pri_q,
    input wire logic [15:0] acc_sec_q,
    input wire logic [15:0] idx_x_q,
    input wire logic [15:0] stack_q,
    input wire logic [15:0] program_counter_q,
    input wire logic [7:0] program_bank_q,
    input wire logic [7:0] data_bank_q,
    input wire logic [15:0] direct_page_base_q,
    input wire logic [10:0] processor_status_q,
    input wire logic operand_width_flag,
    input wire logic pointer_width_flag,
    input wire logic [23:0] eff_addr
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // the flags must follow what was written into the status word
    property p_flags;
        wr.valid && wr.sel == crf_pkg::CRF_SEL_STATUS
        |=> {operand_width_flag, pointer_width_flag} == $past(wr.data[5:4]);
    endproperty
    a_flags: assert property (p_flags)
        else $error("width flags do not follow status write");
    property p_acc_byte;
        wr.valid && wr.sel == crf_pkg::CRF_SEL_ACC_PRI && operand_width_flag
        |=> acc_pri_q == {$past(acc_pri_q[15:8]), $past(wr.data[7:0])};
    endproperty
    a_acc_byte: assert property (p_acc_byte)
        else $error("byte write to primary accumulator wrong");
    property p_sec_word;
        wr.valid && wr.sel == crf_pkg::CRF_SEL_ACC_SEC && !operand_width_flag
        |=> acc_sec_q == $past(wr.data);
    endproperty
    a_sec_word: assert property (p_sec_word)
        else $error("word write to secondary accumulator wrong");
    property p_idx_byte;
        wr.valid && wr.sel == crf_pkg::CRF_SEL_IDX_X && pointer_width_flag
        |=> idx_x_q == {$past(idx_x_q[15:8]), $past(wr.data[7:0])};
    endproperty
    a_idx_byte: assert property (p_idx_byte)
        else $error("byte write to index register wrong");
    property p_stack;
        wr.valid && wr.sel == crf_pkg::CRF_SEL_STACK
        |=> stack_q == $past(wr.data);
    endproperty
    a_stack: assert property (p_stack)
        else $error("stack pointer write wrong");
    property p_pc_carry;
        pc_ctl.inc && !pc_ctl.load && program_counter_q == 16'hffff
        |=> program_counter_q == 16'h0000
            && program_bank_q == $past(program_bank_q) + 8'h01;
    endproperty
    a_pc_carry: assert property (p_pc_carry)
        else $error("program counter carry not into bank");
    property p_pc_load;
        pc_ctl.load |=> program_counter_q == $past(pc_ctl.target);
    endproperty
    a_pc_load: assert property (p_pc_load)
        else $error("program counter load wrong");
    property p_dp_ea;
        addr_req.base == crf_pkg::CRF_BASE_DPAGE
        && addr_req.idx == crf_pkg::CRF_IDX_NONE
        |=> eff_addr == ($past(addr_req.use_bank) ?
            {$past(data_bank_q), 16'h0000} : 24'h00_0000)
            + {8'h00, $past(direct_page_base_q)}
            + {8'h00, $past(addr_req.offset)};
    endproperty
    a_dp_ea: assert property (p_dp_ea)
        else $error("direct page address wrong");
endmodule // crf_checker
bind crf_cpu_register_file crf_checker i_chk (
    .clk(clk),
    .rstn(rstn),
    .wr(wr),
    .pc_ctl(pc_ctl),
    .addr_req(addr_req),
    .acc_pri_q(acc_pri_q),
    .acc_sec_q(acc_sec_q),
    .idx_x_q(idx_x_q),
    .stack_q(stack_q),
    .program_counter_q(program_counter_q),
    .program_bank_q(program_bank_q),
    .data_bank_q(data_bank_q),
    .direct_page_base_q(direct_page_base_q),
    .processor_status_q(processor_status_q),
    .operand_width_flag(operand_width_flag),
    .pointer_width_flag(pointer_width_flag),
    .eff_addr(eff_addr)
);

// ---- tb/crf_cpu_register_file_bench.sv ----
// bench: random register writes, pc wrap, addresses, table pointers
// assumes the fetch unit model and the checker bound to the design
`timescale 1ns/1ps
module crf_cpu_register_file_bench;
    logic clk, rstn, table_pointer_mode, slow, fetch_ready, fetch_valid;
    logic operand_width_flag, pointer_width_flag, by;
    crf_pkg::crf_write_type wr;
    crf_pkg::crf_pc_ctl_type pc_ctl;
    crf_pkg::crf_addr_req_type addr_req;
    logic [15:0] acc_pri_q, acc_sec_q, idx_x_q, idx_y_q, stack_q;
    logic [15:0] program_counter_q, direct_page_base_q;
    logic [7:0] program_bank_q, data_bank_q, ex_db;
    logic [10:0] processor_status_q, ex_st;
    logic [23:0] eff_addr, src_table_addr, dst_table_addr, fetch_addr;
    logic [23:0] ex_ea; // expected effective address
    logic [15:0] ex [0:5]; // expected words, indexed by selector code
    logic [31:0] seed = 32'h0000_c712;
    int bad_count = 0;
    int checked = 0;
    int k, n;
    crf_cpu_register_file i_dut (
        .clk(clk),
        .rstn(rstn),
        .wr(wr),
        .pc_ctl(pc_ctl),
        .addr_req(addr_req),
        .table_pointer_mode(table_pointer_mode),
        .fetch_ready(fetch_ready),
        .acc_pri_q(acc_pri_q),
        .acc_sec_q(acc_sec_q),
        .idx_x_q(idx_x_q),
        .idx_y_q(idx_y_q),
        .stack_q(stack_q),
        .program_counter_q(program_counter_q),
        .program_bank_q(program_bank_q),
        .data_bank_q(data_bank_q),
        .direct_page_base_q(direct_page_base_q),
        .processor_status_q(processor_status_q),
        .operand_width_flag(operand_width_flag),
        .pointer_width_flag(pointer_width_flag),
        .eff_addr(eff_addr),
        .src_table_addr(src_table_addr),
        .dst_table_addr(dst_table_addr),
        .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr)
    );
    crf_fetch_unit i_fu (
        .clk(clk),
        .rstn(rstn),
        .slow(slow),
        .fetch_valid(fetch_valid),
        .fetch_ready(fetch_ready)
    );
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic logic [15:0] cur(input int s);
        case (s)
            0: return acc_pri_q;
            1: return acc_sec_q;
            2: return idx_x_q;
            3: return idx_y_q;
            4: return stack_q;
            default: return direct_page_base_q;
        endcase
    endfunction
    // byte width touches only the low byte
    function automatic logic [15:0] nxt(input logic [15:0] o, d,
                                        input logic b);
        return b ? {o[15:8], d[7:0]} : d;
    endfunction
    function automatic logic [23:0] ea_exp(input int b, x, input logic u,
                                           input logic [15:0] o);
        logic [15:0] bv, iv;
        bv = (b == 1) ? ex[5] : (b == 2) ? ex[4] : 16'h0000;
        iv = (x == 1) ? ex[2] : (x == 2) ? ex[3] : 16'h0000;
        if (ex_st[4]) iv[15:8] = 8'h00;
        return (u ? {ex_db, 16'h0000} : 24'h00_0000) + {8'h00, bv}
            + {8'h00, o} + {8'h00, iv};
    endfunction
    task automatic chk(input logic [23:0] got, exp, input string m);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic wreg(input logic [2:0] s, input logic [15:0] d);
        @(posedge clk);
        wr <= '{valid: 1'b1, sel: crf_pkg::crf_sel_type'(s), data: d};
        @(posedge clk);
        wr.valid <= 1'b0;
        #1;
    endtask
    task automatic wrap_up();
        $display("checked %0d, bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        wr = '0;
        pc_ctl = '0;
        addr_req = '0;
        table_pointer_mode = 1'b0;
        slow = 1'b0;
        rstn = 1'b0;
        foreach (ex[i]) ex[i] = 16'h0000;
        ex_st = 11'h004;
        ex_db = 8'h00;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk(processor_status_q, ex_st, "status reset");
        chk(acc_pri_q, 16'h0000, "accumulator reset");
        // random writes; every eighth sets the width flags in turn
        for (int i = 0; i < 64; i++) begin
            seed = xs(seed);
            if (i % 8 == 0) begin
                seed[5:4] = i[4:3];
                ex_st = seed[10:0];
                wreg(3'h7, seed[15:0]);
                chk(processor_status_q, ex_st, "status");
            end else if (seed[18:16] > 3'h5) begin
                ex_db = seed[7:0];
                wreg(3'h6, seed[15:0]);
                chk(data_bank_q, ex_db, "data bank");
            end else begin
                k = seed[18:16];
                by = (k < 2) ? ex_st[5] : (k < 4) ? ex_st[4] : 1'b0;
                ex[k] = nxt(ex[k], seed[15:0], by);
                wreg(k[2:0], seed[15:0]);
                chk(cur(k), ex[k], "write");
            end
        end
        $display("test writes done");
        // load with increment at once, then wrap over the bank edge
        @(posedge clk);
        slow <= 1'b1;
        pc_ctl <= '{1'b1, 1'b1, 16'hffff, 8'h02, 1'b1};
        @(posedge clk);
        pc_ctl <= '{1'b1, 1'b0, 16'h0000, 8'h00, 1'b0};
        #1;
        chk({program_bank_q, program_counter_q},
            24'h02_ffff, "load");
        @(posedge clk);
        pc_ctl <= '0;
        #1;
        chk({program_bank_q, program_counter_q},
            24'h03_0000, "wrap");
        @(posedge clk);
        #1;
        for (n = 0; n < 20 && fetch_valid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk(n < 20, 1'b1, "fetch wait");
        if (n >= 20) begin
            // limit used up: go straight to the report
            wrap_up();
        end
        chk(fetch_addr, 24'h03_0000, "fetch address");
        $display("test program counter done");
        // every base with every index, pointers currently byte wide
        for (int b = 0; b < 3; b++) begin
            for (int x = 0; x < 3; x++) begin
                seed = xs(seed);
                @(posedge clk);
                addr_req <= '{crf_pkg::crf_base_type'(b),
                    crf_pkg::crf_idx_type'(x), seed[16], seed[15:0]};
                @(posedge clk);
                #1;
                ex_ea = ea_exp(b, x, seed[16], seed[15:0]);
                chk(eff_addr, ex_ea, "ea");
            end
        end
        chk(src_table_addr, 24'h00_0000, "table off");
        @(posedge clk);
        table_pointer_mode <= 1'b1;
        @(posedge clk);
        #1;
        chk(src_table_addr, {ex_db, ex[2]}, "source table");
        chk(dst_table_addr, {ex_db, ex[3]}, "target table");
        $display("test addresses done");
        wrap_up();
    end
endmodule // crf_cpu_register_file_bench

// ---- tb/crf_fetch_unit.sv ----
// model of the bus interface unit taking program fetch requests
// assumes fetch_valid holds until fetch_ready is seen at an edge
`timescale 1ns/1ps
module crf_fetch_unit (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic fetch_valid,
    output logic fetch_ready
);
    logic [1:0] wait_reg; // stall phase, only used when slow
    // free running phase counter; slow mode accepts one edge in four
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_reg <= 2'h0;
        end else begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
    // fetches only complete through this unit, never from the core
    assign fetch_ready = fetch_valid
        && (!slow || wait_reg == 2'h3);
endmodule // crf_fetch_unit

// ---- verilog/crf_cpu_register_file.sv ----
// programmer-visible register set of a 16-bit core with 8-bit modes
// assumes execution logic on clk drives writes and pc controls, and a
// bus interface unit that accepts program fetch requests by handshake
`timescale 1ns/1ps
`include "crf_regs.svh"

module crf_cpu_register_file (
    input wire logic clk,
    input wire logic rstn,
    input wire crf_pkg::crf_write_type wr,
    input wire crf_pkg::crf_pc_ctl_type pc_ctl,
    input wire crf_pkg::crf_addr_req_type addr_req,
    input wire logic table_pointer_mode,
    input wire logic fetch_ready,
    output logic [15:0] acc_pri_q,
    output logic [15:0] acc_sec_q,
    output logic [15:0] idx_x_q,
    output logic [15:0] idx_y_q,
    output logic [15:0] stack_q,
    output logic [15:0] program_counter_q,
    output logic [7:0] program_bank_q,
    output logic [7:0] data_bank_q,
    output logic [15:0] direct_page_base_q,
    output logic [10:0] processor_status_q,
    output logic operand_width_flag,
    output logic pointer_width_flag,
    output logic [23:0] eff_addr,
    output logic [23:0] src_table_addr,
    output logic [23:0] dst_table_addr,
    output logic fetch_valid,
    output logic [23:0] fetch_addr
);

    // ****************************************
    // state and next state
    // ****************************************
    crf_pkg::crf_state_type state_reg; // all held state
    crf_pkg::crf_state_type state_next; // value for next edge
    logic op8; // accumulators in byte width
    logic ix8; // index registers in byte width
    logic [15:0] idx_val; // selected index contribution
    logic [15:0] base_val; // selected address base
    logic [16:0] pc_sum; // pc plus one with carry

    // width flags come out of the status word, no separate storage
    assign op8 = state_reg.status[`CRF_PS_OPERAND_BIT]; // see [RL11]
    assign ix8 = state_reg.status[`CRF_PS_POINTER_BIT]; // see [RL11]

    // ****************************************
    // next state logic
    // ****************************************
    // one write port; byte-width writes keep the upper byte so a later
    // switch to word width sees the old high half
    always_comb begin
        state_next = state_reg;
        idx_val = 16'h0000;
        base_val = 16'h0000;
        pc_sum = {1'b0, state_reg.pc} + {1'b0, `CRF_PC_STEP};
        if (wr.valid) begin
            unique case (wr.sel)
                crf_pkg::CRF_SEL_ACC_PRI: begin
                    // main operand register, byte or word
                    if (op8) begin // see [RL2]
                        state_next.acc_pri[7:0] = wr.data[7:0]; // see [RL15]
                    end else begin
                        state_next.acc_pri = wr.data; // see [RL1]
                    end
                end
                crf_pkg::CRF_SEL_ACC_SEC: begin
                    // same behaviour; extra cost lies in the decoder
                    if (op8) begin // see [RL3]
                        state_next.acc_sec[7:0] = wr.data[7:0]; // see [RL15]
                    end else begin
                        state_next.acc_sec = wr.data; // see [RL3]
                    end
                end
                crf_pkg::CRF_SEL_IDX_X: begin
                    // the pointer flag decides how much is written
                    if (ix8) begin // see [RL4]
                        state_next.idx_x[7:0] = wr.data[7:0]; // see [RL15]
                    end else begin
                        state_next.idx_x = wr.data; // see [RL4]
                    end
                end
                crf_pkg::CRF_SEL_IDX_Y: begin
                    // same width rule as the x register
                    if (ix8) begin // see [RL4]
                        state_next.idx_y[7:0] = wr.data[7:0]; // see [RL15]
                    end else begin
                        state_next.idx_y = wr.data; // see [RL4]
                    end
                end
                crf_pkg::CRF_SEL_STACK: begin
                    // always full width; pushes and pulls write it here
                    state_next.stack = wr.data; // see [RL7]
                end
                crf_pkg::CRF_SEL_DPAGE: begin
                    // full word; the page may start anywhere in bank zero
                    state_next.dpage = wr.data; // see [RL14]
                end
                crf_pkg::CRF_SEL_DBANK: begin
                    // only a byte exists; the upper data bits are dropped
                    state_next.data_bank = wr.data[7:0]; // see [RL13]
                end
                crf_pkg::CRF_SEL_STATUS: begin
                    // upper five bits of the word do not exist
                    state_next.status = wr.data[10:0]; // see [RL11]
                end
            endcase
        end
        // program counter: load wins over increment
        if (pc_ctl.load) begin
            state_next.pc = pc_ctl.target; // see [RL9]
            if (pc_ctl.load_bank) begin
                // a long jump replaces the bank as well
                state_next.prog_bank = pc_ctl.bank;
            end
        end else if (pc_ctl.inc) begin
            state_next.pc = pc_sum[15:0]; // see [RL9]
            if (pc_sum[16]) begin
                // crossing a 64k bank keeps execution running
                state_next.prog_bank = state_reg.prog_bank
                                     + 8'h01; // see [RL12]
            end
        end
        // re-arming repeats the current address so the bus unit never
        // starves; the price is redundant fetches while the core waits
        // fetch request held until the bus unit takes it
        if (state_reg.fetch_req && fetch_ready) begin
            state_next.fetch_req = 1'b0;
        end
        if (pc_ctl.load || pc_ctl.inc || !state_next.fetch_req) begin
            state_next.fetch_req = 1'b1; // see [RL10]
            state_next.fetch_addr = {state_next.prog_bank,
                                     state_next.pc}; // see [RL10]
        end
        // index contribution; byte width counts only the low byte
        unique case (addr_req.idx)
            crf_pkg::CRF_IDX_X: begin
                idx_val = ix8 ? {8'h00, state_reg.idx_x[7:0]}
                              : state_reg.idx_x;
            end
            crf_pkg::CRF_IDX_Y: begin
                idx_val = ix8 ? {8'h00, state_reg.idx_y[7:0]}
                              : state_reg.idx_y;
            end
            default: begin
                // code 3 is unused and treated as no index
                idx_val = 16'h0000;
            end
        endcase
        unique case (addr_req.base)
            crf_pkg::CRF_BASE_DPAGE: begin
                base_val = state_reg.dpage; // see [RL14]
            end
            crf_pkg::CRF_BASE_STACK: begin
                base_val = state_reg.stack; // see [RL8]
            end
            default: begin
                // absolute forms carry the whole base in the offset
                base_val = 16'h0000;
            end
        endcase
        // registered effective address, one cycle behind the request;
        // direct page may run into bank one, so keep the carry
        // limitation: a sum past the top bank wraps silently
        state_next.eff_addr = {(addr_req.use_bank ? state_reg.data_bank
                                                 : 8'h00), 16'h0000}
                            + {8'h00, base_val}
                            + {8'h00, addr_req.offset}
                            + {8'h00, idx_val}; // see [RL5] see [RL13]
    end

    // ****************************************
    // state register
    // ****************************************
    // reset loads constants only, never anything from the inputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '{acc_pri: `CRF_WORD_RESET,
                           acc_sec: `CRF_WORD_RESET,
                           idx_x: `CRF_WORD_RESET,
                           idx_y: `CRF_WORD_RESET,
                           stack: `CRF_WORD_RESET,
                           pc: `CRF_WORD_RESET,
                           prog_bank: `CRF_BYTE_RESET,
                           data_bank: `CRF_BYTE_RESET,
                           dpage: `CRF_WORD_RESET,
                           status: `CRF_PS_RESET,
                           fetch_req: 1'b0,
                           fetch_addr: 24'h00_0000,
                           eff_addr: 24'h00_0000};
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // registers are shown straight from the state flops
    assign acc_pri_q = state_reg.acc_pri;
    assign acc_sec_q = state_reg.acc_sec;
    assign idx_x_q = state_reg.idx_x;
    assign idx_y_q = state_reg.idx_y;
    assign stack_q = state_reg.stack;
    assign program_counter_q = state_reg.pc;
    assign program_bank_q = state_reg.prog_bank;
    assign data_bank_q = state_reg.data_bank;
    assign direct_page_base_q = state_reg.dpage;
    assign processor_status_q = state_reg.status;
    assign operand_width_flag = op8;
    assign pointer_width_flag = ix8;
    assign eff_addr = state_reg.eff_addr;
    // table pointers for block moves and multiply-accumulate: x is the
    // source, y the destination; without the mode they read as zero
    assign src_table_addr = table_pointer_mode
        ? {state_reg.data_bank, state_reg.idx_x} : 24'h00_0000; // see [RL6]
    assign dst_table_addr = table_pointer_mode
        ? {state_reg.data_bank, state_reg.idx_y} : 24'h00_0000; // see [RL6]
    assign fetch_valid = state_reg.fetch_req; // see [RL10]
    assign fetch_addr = state_reg.fetch_addr;

endmodule // crf_cpu_register_file

// ---- verilog/crf_pkg.sv ----
// types shared by the cpu register file and its users
// assumes crf_regs.svh is not needed here; codes are written out
package crf_pkg;

    // ****************************************
    // register selectors used by the execution logic
    // ****************************************
    typedef enum logic [2:0] {
        CRF_SEL_ACC_PRI = 3'h0,
        CRF_SEL_ACC_SEC = 3'h1,
        CRF_SEL_IDX_X = 3'h2,
        CRF_SEL_IDX_Y = 3'h3,
        CRF_SEL_STACK = 3'h4,
        CRF_SEL_DPAGE = 3'h5,
        CRF_SEL_DBANK = 3'h6,
        CRF_SEL_STATUS = 3'h7
    } crf_sel_type;

    // address base for effective address formation
    typedef enum logic [1:0] {
        CRF_BASE_ABS = 2'h0,
        CRF_BASE_DPAGE = 2'h1,
        CRF_BASE_STACK = 2'h2
    } crf_base_type;

    // index selection for indexed modes
    typedef enum logic [1:0] {
        CRF_IDX_NONE = 2'h0,
        CRF_IDX_X = 2'h1,
        CRF_IDX_Y = 2'h2
    } crf_idx_type;

    // one write request from the execution logic
    typedef struct packed {
        logic valid;
        crf_sel_type sel;
        logic [15:0] data;
    } crf_write_type;

    // effective address request
    typedef struct packed {
        crf_base_type base;
        crf_idx_type idx;
        logic use_bank;
        logic [15:0] offset;
    } crf_addr_req_type;

    // program counter control
    typedef struct packed {
        logic inc;
        logic load;
        logic [15:0] target;
        logic [7:0] bank;
        logic load_bank;
    } crf_pc_ctl_type;

    // whole state of the block
    typedef struct packed {
        logic [15:0] acc_pri;
        logic [15:0] acc_sec;
        logic [15:0] idx_x;
        logic [15:0] idx_y;
        logic [15:0] stack;
        logic [15:0] pc;
        logic [7:0] prog_bank;
        logic [7:0] data_bank;
        logic [15:0] dpage;
        logic [10:0] status;
        logic fetch_req;
        logic [23:0] fetch_addr;
        logic [23:0] eff_addr;
    } crf_state_type;

endpackage

// ---- verilog/crf_regs.svh ----
// register file constants: field positions, reset values, widths
// assumes an includer that wants plain `define macros, no logic here
//
// Overview of operation
// [RL1] primary accumulator 16 bits, low byte separately
// [RL2] operand flag 0 selects 16, 1 selects 8
// [RL3] secondary accumulator mirrors primary, costlier to use
// [RL4] two index registers, width chosen by pointer flag
// [RL5] indexed modes add index to base address
// [RL6] block moves and multiply-accumulate use index pointers
// [RL7] 16-bit stack pointer saves and restores context
// [RL8] stack pointer is base for stack modes
// [RL9] program counter holds low 16 address bits
// [RL10] program fetches go through bus interface unit
// [RL11] width flags live inside processor status
// [RL12] program counter carry bumps program bank
// [RL13] data bank supplies upper address byte
// [RL14] direct page base anchors 256-byte page
// [RL15] 8-bit writes leave upper byte unchanged
`ifndef CRF_REGS_SVH
`define CRF_REGS_SVH

// ****************************************
// processor status field positions
// ****************************************
`define CRF_PS_WIDTH 11
`define CRF_PS_POINTER_BIT 4
`define CRF_PS_OPERAND_BIT 5
`define CRF_PS_RESET 11'h004

// ****************************************
// reset values of the register set, pc step and direct page span
// ****************************************
`define CRF_WORD_RESET 16'h0000
`define CRF_BYTE_RESET 8'h00
`define CRF_PC_STEP 16'h0001
`define CRF_DP_SPAN 16'h0100

`endif
